// ---- hdl/acl_match_pkg.sv ----
// Purpose: constants and types for the ipv4 access list entry matcher
// Assumes: 32-bit register words, 8-bit register index
// Notes:   offsets are word indices on the plain register port
`default_nettype none
package acl_match_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PROTO    = 8'h01;
	localparam logic [7:0] OFS_SRC_ADDR = 8'h02;
	localparam logic [7:0] OFS_SRC_MASK = 8'h03;
	localparam logic [7:0] OFS_DST_ADDR = 8'h04;
	localparam logic [7:0] OFS_DST_MASK = 8'h05;
	localparam logic [7:0] OFS_STATUS   = 8'h06;
	localparam logic [7:0] OFS_HIT_CNT  = 8'h07;

	// control field positions
	localparam int CTL_FTYPE_LSB = 0;
	localparam int CTL_PROTO_LSB = 2;
	localparam int CTL_TTL_LSB   = 5;
	localparam int CTL_FRAG_LSB  = 7;
	localparam int CTL_OPT_LSB   = 9;
	localparam int CTL_SRC_LSB   = 11;
	localparam int CTL_DST_LSB   = 13;
	localparam int CTL_USED      = 15;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;

	// standard ip protocol numbers
	localparam logic [7:0] PROTO_ICMP = 8'h01;
	localparam logic [7:0] PROTO_TCP  = 8'h06;
	localparam logic [7:0] PROTO_UDP  = 8'h11;

	typedef enum logic [1:0] {FT_ANY, FT_IPV4, FT_OTHER} frame_sel_t;
	typedef enum logic [2:0] {PR_ANY, PR_SPECIFIC, PR_ICMP, PR_UDP,
		PR_TCP} proto_sel_t;
	typedef enum logic [1:0] {TRI_ANY, TRI_NO, TRI_YES} tri_sel_t;
	typedef enum logic [1:0] {AD_ANY, AD_HOST, AD_NET} addr_sel_t;
endpackage : acl_match_pkg
`default_nettype wire

// ---- hdl/addr_cond.sv ----
// Purpose: one ipv4 address condition (any, host or masked network)
// Assumes: combinational, same clock domain as the caller
// Notes:   instantiated for source and destination
`default_nettype none
module addr_cond
	import acl_match_pkg::*;
(
	input  wire logic [1:0]  sel,
	input  wire logic [31:0] cfg_addr,
	input  wire logic [31:0] cfg_mask,
	input  wire logic [31:0] frm_addr,
	output logic             ok
);
	always_comb
	begin
		unique case (addr_sel_t'(sel))
			AD_ANY:  ok = 1'b1;
			AD_HOST: ok = (frm_addr == cfg_addr);
			AD_NET:  ok = ((frm_addr & cfg_mask) == (cfg_addr & cfg_mask));
			default: ok = 1'b0; // unused code never matches
		endcase
	end
endmodule // addr_cond
`default_nettype wire

// ---- hdl/acl_entry_match.sv ----
// Purpose: decide whether an ipv4 frame hits one access list entry
// Assumes: parser gives a one-cycle header strobe with parsed fields
// Notes:   result is registered one cycle after the strobe
`default_nettype none
// Operation
// - entries hit only when entry frame type selects ipv4 and the frame is ipv4
// - protocol any ignores frame protocol number
// - specific protocol hits only on equal 8-bit protocol field
// - icmp, udp or tcp selection restricts protocol, enables sub-conditions when frame type selects ipv4
// - ttl zero rejects frames with ttl above zero
// - ttl non-zero allows ttl above zero; any ignores ttl
// - fragment no rejects more-fragments set or offset above zero
// - fragment yes needs fragmentation; any ignores it
// - options no rejects frames with options indication set
// - options yes needs options; any ignores the indication
// - source any ignores the source address
// - source host needs exact source address equality
// - source network compares source with address and mask
// - destination any ignores destination address
// - destination host needs exact destination address equality
// - destination network compares with address and mask
module acl_entry_match
	import acl_match_pkg::*;
(
	input  wire logic                REF_CLK,
	input  wire logic                RESET,
	input  wire logic [ADDR_W-1:0]   REG_ADDR,
	input  wire logic [DATA_W-1:0]   REG_WDATA,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	output logic      [DATA_W-1:0]   REG_RDATA,
	input  wire logic                HDR_VALID,
	input  wire logic                HDR_IS_IPV4,
	input  wire logic [7:0]          HDR_PROTO,
	input  wire logic [7:0]          HDR_TTL,
	input  wire logic                HDR_MORE_FRAG,
	input  wire logic [12:0]         HDR_FRAG_OFS,
	input  wire logic                HDR_HAS_OPT,
	input  wire logic [31:0]         HDR_SRC_ADDR,
	input  wire logic [31:0]         HDR_DST_ADDR,
	output logic                     MATCH_VALID,
	output logic                     MATCH_HIT,
	output logic                     SUB_ICMP_EN,
	output logic                     SUB_UDP_EN,
	output logic                     SUB_TCP_EN
);
	// configuration registers
	logic [CTL_USED-1:0] ctrl_q, ctrl_d;
	logic [7:0]          proto_q, proto_d;
	logic [31:0]         src_addr_q, src_addr_d;
	logic [31:0]         src_mask_q, src_mask_d;
	logic [31:0]         dst_addr_q, dst_mask_q;
	logic [31:0]         dst_addr_d, dst_mask_d;
	logic [31:0]         rdata_q, rdata_d;
	// match state
	logic                valid_q, valid_d;
	logic                hit_q, hit_d;
	logic                last_hit_q, last_hit_d;
	logic [31:0]         hit_cnt_q, hit_cnt_d;

	// decoded fields
	logic [1:0] ftype_f;
	logic [2:0] proto_f;
	logic [1:0] ttl_f, frag_f, opt_f, src_f, dst_f;
	assign ftype_f = ctrl_q[CTL_FTYPE_LSB +: 2];
	assign proto_f = ctrl_q[CTL_PROTO_LSB +: 3];
	assign ttl_f   = ctrl_q[CTL_TTL_LSB +: 2];
	assign frag_f  = ctrl_q[CTL_FRAG_LSB +: 2];
	assign opt_f   = ctrl_q[CTL_OPT_LSB +: 2];
	assign src_f   = ctrl_q[CTL_SRC_LSB +: 2];
	assign dst_f   = ctrl_q[CTL_DST_LSB +: 2];

	// register port
	always_comb
	begin
		ctrl_d     = ctrl_q;
		proto_d    = proto_q;
		src_addr_d = src_addr_q;
		src_mask_d = src_mask_q;
		dst_addr_d = dst_addr_q;
		dst_mask_d = dst_mask_q;
		rdata_d    = WORD_ZERO;
		if (REG_WR)
		begin
			unique case (REG_ADDR)
				OFS_CTRL:     ctrl_d     = REG_WDATA[CTL_USED-1:0];
				OFS_PROTO:    proto_d    = REG_WDATA[7:0];
				OFS_SRC_ADDR: src_addr_d = REG_WDATA;
				OFS_SRC_MASK: src_mask_d = REG_WDATA;
				OFS_DST_ADDR: dst_addr_d = REG_WDATA;
				OFS_DST_MASK: dst_mask_d = REG_WDATA;
				default:      ;
			endcase
		end
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				OFS_CTRL:     rdata_d = {{(32-CTL_USED){1'b0}}, ctrl_q};
				OFS_PROTO:    rdata_d = {24'h00_0000, proto_q};
				OFS_SRC_ADDR: rdata_d = src_addr_q;
				OFS_SRC_MASK: rdata_d = src_mask_q;
				OFS_DST_ADDR: rdata_d = dst_addr_q;
				OFS_DST_MASK: rdata_d = dst_mask_q;
				OFS_STATUS:   rdata_d = {30'h0000_0000, last_hit_q, valid_q};
				OFS_HIT_CNT:  rdata_d = hit_cnt_q;
				default:      rdata_d = WORD_ZERO; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			ctrl_q     <= CTRL_RESET[CTL_USED-1:0];
			proto_q    <= 8'h00;
			src_addr_q <= WORD_ZERO;
			src_mask_q <= MASK_RESET;
			dst_addr_q <= WORD_ZERO;
			dst_mask_q <= MASK_RESET;
			rdata_q    <= WORD_ZERO;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			proto_q    <= proto_d;
			src_addr_q <= src_addr_d;
			src_mask_q <= src_mask_d;
			dst_addr_q <= dst_addr_d;
			dst_mask_q <= dst_mask_d;
			rdata_q    <= rdata_d;
		end
	end
	assign REG_RDATA = rdata_q;

	// address conditions
	logic src_ok, dst_ok;
	addr_cond u_src (
		.sel      (src_f),
		.cfg_addr (src_addr_q),
		.cfg_mask (src_mask_q),
		.frm_addr (HDR_SRC_ADDR),
		.ok       (src_ok)
	);
	addr_cond u_dst (
		.sel      (dst_f),
		.cfg_addr (dst_addr_q),
		.cfg_mask (dst_mask_q),
		.frm_addr (HDR_DST_ADDR),
		.ok       (dst_ok)
	);

	// header conditions
	logic proto_ok, ttl_ok, frag_ok, opt_ok, is_frag, ipv4_sel;
	assign is_frag  = HDR_MORE_FRAG || (HDR_FRAG_OFS != 13'h0000);
	assign ipv4_sel = (frame_sel_t'(ftype_f) == FT_IPV4);

	always_comb
	begin
		unique case (proto_sel_t'(proto_f))
			PR_ANY:      proto_ok = 1'b1;
			PR_SPECIFIC: proto_ok = (HDR_PROTO == proto_q);
			PR_ICMP:     proto_ok = (HDR_PROTO == PROTO_ICMP);
			PR_UDP:      proto_ok = (HDR_PROTO == PROTO_UDP);
			PR_TCP:      proto_ok = (HDR_PROTO == PROTO_TCP);
			default:     proto_ok = 1'b0;
		endcase
		unique case (tri_sel_t'(ttl_f))
			TRI_ANY: ttl_ok = 1'b1;
			TRI_NO:  ttl_ok = (HDR_TTL == 8'h00);
			TRI_YES: ttl_ok = (HDR_TTL != 8'h00);
			default: ttl_ok = 1'b0;
		endcase
		unique case (tri_sel_t'(frag_f))
			TRI_ANY: frag_ok = 1'b1;
			TRI_NO:  frag_ok = !is_frag;
			TRI_YES: frag_ok = is_frag;
			default: frag_ok = 1'b0;
		endcase
		unique case (tri_sel_t'(opt_f))
			TRI_ANY: opt_ok = 1'b1;
			TRI_NO:  opt_ok = !HDR_HAS_OPT;
			TRI_YES: opt_ok = HDR_HAS_OPT;
			default: opt_ok = 1'b0;
		endcase
	end

	// sub-filter enables follow the protocol choice when frame type selects ipv4
	assign SUB_ICMP_EN = ipv4_sel && (proto_sel_t'(proto_f) == PR_ICMP);
	assign SUB_UDP_EN  = ipv4_sel && (proto_sel_t'(proto_f) == PR_UDP);
	assign SUB_TCP_EN  = ipv4_sel && (proto_sel_t'(proto_f) == PR_TCP);

	// combine and register the verdict
	always_comb
	begin
		valid_d    = HDR_VALID;
		hit_d      = 1'b0;
		last_hit_d = last_hit_q;
		hit_cnt_d  = hit_cnt_q;
		if (HDR_VALID)
		begin
			// non-ipv4 entry selection leaves the ipv4 checks unused
			if (ipv4_sel)
				hit_d = HDR_IS_IPV4 && proto_ok && ttl_ok && frag_ok
					&& opt_ok && src_ok && dst_ok;
			last_hit_d = hit_d;
			if (hit_d)
				hit_cnt_d = hit_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			valid_q    <= 1'b0;
			hit_q      <= 1'b0;
			last_hit_q <= 1'b0;
			hit_cnt_q  <= WORD_ZERO;
		end
		else
		begin
			valid_q    <= valid_d;
			hit_q      <= hit_d;
			last_hit_q <= last_hit_d;
			hit_cnt_q  <= hit_cnt_d;
		end
	end
	assign MATCH_VALID = valid_q;
	assign MATCH_HIT   = hit_q;
endmodule // acl_entry_match
`default_nettype wire

// ---- tb/hdr_source.sv ----
// Purpose: header parser model, one parsed header per call
// Assumes: caller enters just after a rising edge
// Notes:   idle fields are inverted so stale values never look valid
`default_nettype none
module hdr_source (
	input  wire logic        clk,
	output logic             valid,
	output logic             v4,
	output logic [7:0]       proto,
	output logic [7:0]       ttl,
	output logic             mf,
	output logic [12:0]      fo,
	output logic             opt,
	output logic [31:0]      sa,
	output logic [31:0]      da
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		valid = 1'b0;
		{v4, proto, ttl, mf, fo, opt, sa, da} = '0;
	end
	task automatic send(input logic v, input logic [95:0] f);
		valid <= v;
		{v4, proto, ttl, mf, fo, opt, sa, da} <= v ? f : ~f;
		@(posedge clk);
	endtask
endmodule // hdr_source
`default_nettype wire

// ---- tb/acl_entry_match_checker.sv ----
// Purpose: port-level checks for the access list entry matcher
// Assumes: bound to acl_entry_match
// Notes:   shadows the control word to judge verdicts
`default_nettype none
module acl_entry_match_checker
	import acl_match_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [31:0] REG_RDATA,
	input  wire logic        HDR_VALID,
	input  wire logic        HDR_IS_IPV4,
	input  wire logic [7:0]  HDR_TTL,
	input  wire logic        HDR_MORE_FRAG,
	input  wire logic [12:0] HDR_FRAG_OFS,
	input  wire logic        HDR_HAS_OPT,
	input  wire logic        MATCH_VALID,
	input  wire logic        MATCH_HIT,
	input  wire logic        SUB_TCP_EN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [14:0] c_q;
	logic [14:0] c_d;
	always_comb
	begin
		c_d = c_q;
		if (REG_WR && REG_ADDR == OFS_CTRL)
			c_d = REG_WDATA[14:0];
	end
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
			c_q <= '0;
		else
			c_q <= c_d;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	sequence s_miss;
		MATCH_VALID && !MATCH_HIT;
	endsequence
	a_verdict_next: assert property (HDR_VALID |=> MATCH_VALID)
		else $error("no verdict after header");
	a_no_stray: assert property (!HDR_VALID |=> !MATCH_VALID && !MATCH_HIT)
		else $error("stray verdict");
	a_ipv4_only: assert property (
		HDR_VALID && (!HDR_IS_IPV4 || c_q[1:0] != 2'h1) |=> s_miss)
		else $error("hit without ipv4 selection");
	a_ttl_zero: assert property (
		HDR_VALID && c_q[6:5] == 2'h1 && HDR_TTL != 8'h00 |=> s_miss)
		else $error("ttl zero mode hit");
	a_frag_no: assert property (
		HDR_VALID && c_q[8:7] == 2'h1 && (HDR_MORE_FRAG
		|| HDR_FRAG_OFS != 13'h0000) |=> s_miss)
		else $error("fragment no mode hit");
	a_frag_yes: assert property (
		HDR_VALID && c_q[8:7] == 2'h2 && !HDR_MORE_FRAG
		&& HDR_FRAG_OFS == 13'h0000 |=> s_miss)
		else $error("fragment yes mode hit");
	a_opt_no: assert property (
		HDR_VALID && c_q[10:9] == 2'h1 && HDR_HAS_OPT |=> s_miss)
		else $error("options no mode hit");
	a_rd_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
		else $error("read data outside read slot");
	a_tcp_sub: assert property (
		SUB_TCP_EN == (c_q[1:0] == 2'h1 && c_q[4:2] == 3'h4))
		else $error("tcp sub-condition enable wrong");
endmodule // acl_entry_match_checker
`default_nettype wire

// ---- tb/acl_entry_match_test.sv ----
// Purpose: self-checking bench for the access list entry matcher
// Assumes: hdr_source model drives headers
// Notes:   random control words cover every selector code
`default_nettype none
module acl_entry_match_test;
	import acl_match_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RV [9] = '{32'h0, 32'h0, 32'h0, MASK_RESET,
		32'h0, MASK_RESET, 32'h0, 32'h0, 32'h0};
	localparam logic [31:0] CV [6] = '{32'h0, 32'h2A, 32'hC0A8_0105,
		32'hFFFF_FF00, 32'h0A00_0001, 32'hFFFF_0000};
	localparam logic [7:0] PT [4] = '{8'h2A, PROTO_ICMP, PROTO_UDP, PROTO_TCP};
	logic        REF_CLK = 0, RESET = 1, REG_WR = 0, REG_RD = 0;
	logic [7:0]  REG_ADDR = '0, HDR_PROTO, HDR_TTL;
	logic [31:0] REG_WDATA = '0, REG_RDATA, HDR_SRC_ADDR, HDR_DST_ADDR;
	logic        HDR_VALID, HDR_IS_IPV4, HDR_MORE_FRAG, HDR_HAS_OPT;
	logic        MATCH_VALID, MATCH_HIT, SUB_ICMP_EN, SUB_UDP_EN, SUB_TCP_EN;
	logic [12:0] HDR_FRAG_OFS;
	logic [31:0] cf [6], rq [$], c;
	logic        hq [$], rd_p = 0, last = 0, h;
	logic [95:0] f;
	int          err_count = 0, n_compared = 0, cyc = 0, nh = 0;
	integer      seed = 99640;
	acl_entry_match u_dut (.*);
	hdr_source u_src (.clk(REF_CLK), .valid(HDR_VALID), .v4(HDR_IS_IPV4),
		.proto(HDR_PROTO), .ttl(HDR_TTL), .mf(HDR_MORE_FRAG),
		.fo(HDR_FRAG_OFS), .opt(HDR_HAS_OPT), .sa(HDR_SRC_ADDR),
		.da(HDR_DST_ADDR));
	always #5 REF_CLK = ~REF_CLK;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// for reads d carries the expected word
	task automatic bus(input logic w, r, input logic [7:0] a,
		input logic [31:0] d);
		REG_WR <= w;
		REG_RD <= r;
		REG_ADDR <= a;
		REG_WDATA <= d;
		if (w && a < 8'h06)
			cf[a] = d;
		if (r)
			rq.push_back(d);
		@(posedge REF_CLK);
	endtask
	function automatic logic tr(logic [1:0] m, logic b);
		return m == 0 || (m == 1 && !b) || (m == 2 && b);
	endfunction
	function automatic logic ad(logic [1:0] m, logic [31:0] a, k, x);
		return m == 0 || (m == 1 && x == a) || (m == 2 && (x & k) == (a & k));
	endfunction
	function automatic logic hit(logic [95:0] v);
		logic [2:0] m;
		m = cf[0][4:2];
		return v[95] && cf[0][1:0] == 1 && (m == 0 || (m == 1 && v[94:87]
			== cf[1][7:0]) || (m > 1 && m < 5 && v[94:87] == PT[m - 1]))
			&& tr(cf[0][6:5], v[86:79] != 0)
			&& tr(cf[0][8:7], v[78] || v[77:65] != 0) && tr(cf[0][10:9], v[64])
			&& ad(cf[0][12:11], cf[2], cf[3], v[63:32])
			&& ad(cf[0][14:13], cf[4], cf[5], v[31:0]);
	endfunction
	always @(posedge REF_CLK)
	begin
		if (rd_p)
			chk(REG_RDATA, rq.pop_front());
		if (MATCH_VALID !== 1'b0)
			chk({31'h0, MATCH_HIT},
				{31'h0, hq.pop_front()});
		rd_p <= REG_RD;
		cyc++;
		if (cyc > 2000)
		begin
			err_count++;
			complete_run;
		end
	end
	initial
	begin
		foreach (cf[i]) cf[i] = RV[i];
		repeat (4) @(posedge REF_CLK);
		RESET <= 0;
		foreach (RV[i]) bus(0, 1, i[7:0], RV[i]);
		bus(1, 0, OFS_HIT_CNT, 32'hFF);
		bus(0, 1, OFS_HIT_CNT, 32'h0);
		for (int i = 1; i < 6; i++) bus(1, 0, i[7:0], CV[i]);
		for (int i = 1; i < 6; i++) bus(0, 1, i[7:0], CV[i]);
		repeat (150)
		begin
			c = $random(seed) & 32'h7FFF;
			// non-ipv4 entries also meet otherwise passing fields
			if ($random(seed) & 3)
				c[1:0] = 2'h1;
			// fold half the never-hit code 3 selections of the ttl to destination fields, else hits are rare
			for (int k = CTL_TTL_LSB; k < CTL_USED; k += 2)
				if (c[k +: 2] == 2'h3 && ($random(seed) & 1))
					c[k +: 2] = 2'h0;
			bus(1, 0, OFS_CTRL, c);
			REG_WR <= 0;
			repeat (2)
			begin
				f = {$random(seed), $random(seed), $random(seed)};
				f[95] = f[95] | f[2];
				f[94:87] = PT[f[89:88]];
				f[86:80] = '0;
				f[77:66] = '0;
				f[63:32] = cf[2] ^ (f[63:32] & 32'h0000_0101);
				f[31:0] = cf[4] ^ (f[31:0] & 32'h0001_0001);
				// half the frames are shaped to suit the entry
				if ($random(seed) & 1)
				begin
					f[95] = 1'b1;
					f[94:87] = PT[2'(c[4:2] - 3'h1)];
					f[79] = c[6:5] == 2'h2;
					f[78] = c[8:7] == 2'h2;
					f[65] = 1'b0;
					f[64] = c[10:9] == 2'h2;
					f[63:32] = cf[2] ^ ({32{c[12]}} & f[63:32] & 32'h0000_00FF);
					f[31:0] = cf[4] ^ ({32{c[14]}} & f[31:0] & 32'h0000_FFFF);
				end
				h = hit(f);
				hq.push_back(h);
				nh += h;
				last = h;
				u_src.send(1, f);
			end
			chk({29'h0, SUB_ICMP_EN, SUB_UDP_EN, SUB_TCP_EN},
				{29'h0, c[1:0] == 1 && c[4:2] == 2, c[1:0] == 1 && c[4:2] == 3,
				c[1:0] == 1 && c[4:2] == 4});
			u_src.send(0, f);
		end
		// status read while a verdict stands shows the valid bit
		h = hit(f);
		hq.push_back(h);
		nh += h;
		last = h;
		u_src.send(1, f);
		REG_RD <= 1'b1;
		REG_ADDR <= OFS_STATUS;
		rq.push_back({30'h0, h, 1'b1});
		u_src.send(0, f);
		bus(0, 1, OFS_HIT_CNT, nh);
		bus(0, 1, OFS_STATUS, {30'h0, last, 1'b0});
		bus(0, 0, 8'h00, 32'h0);
		repeat (2) @(posedge REF_CLK);
		chk(32'(hq.size()), 32'h0);
		chk(32'(rq.size()), 32'h0);
		complete_run;
	end
endmodule // acl_entry_match_test
bind acl_entry_match acl_entry_match_checker u_chk (.REF_CLK, .RESET,
	.REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .HDR_VALID,
	.HDR_IS_IPV4, .HDR_TTL, .HDR_MORE_FRAG, .HDR_FRAG_OFS, .HDR_HAS_OPT,
	.MATCH_VALID, .MATCH_HIT, .SUB_TCP_EN);
`default_nettype wire
